// ---- inc/tdm_port_map.svh ----
`ifndef TDM_PORT_MAP_SVH
`define TDM_PORT_MAP_SVH

// register offsets
`define OFS_CONFIG 8'h00
`define OFS_CTRL 8'h04
`define OFS_STATUS 8'h08
`define OFS_MAP0 8'h10
`define OFS_MAP1 8'h14
`define OFS_MAP2 8'h18
`define OFS_MAP3 8'h1c

// port configuration word fields
`define CFG_DRIVE_ONE 9
`define CFG_OOF_EDGE 8
`define CFG_SYNC_EDGE 7
`define CFG_DATA_EDGE 6
`define CFG_TX_SYNC_EDGE 5
`define CFG_TX_LAUNCH_EDGE 4
`define CFG_MODE_MSB 2
`define CFG_MODE_LSB 0
`define CFG_WRITE_MASK 32'h0000_03f7
`define CFG_RESET 32'h0000_0000

// control word fields
`define CTRL_TX_ENABLE 0
`define CTRL_MAPPING_MSB 2
`define CTRL_MAPPING_LSB 1
`define CTRL_FILL_MSB 15
`define CTRL_FILL_LSB 8
`define CTRL_WRITE_MASK 32'h0000_ff07
`define CTRL_RESET 32'h0000_0000

// status word fields
`define STAT_OOF 0
`define STAT_FRAME_ALIGNMENT_CHANGE_DETECT 1
`define STAT_BYTE_MSB 15
`define STAT_BYTE_LSB 8

`define MAP_RESET 32'h0000_0000

// framing mode codes
`define MODE_T1 3'h0
`define MODE_E1 3'h1
`define MODE_E1X2 3'h2
`define MODE_E1X4 3'h3
`define MODE_NX64 3'h4

// last time slot index per framed mode
`define LAST_SLOT_T1 7'h17
`define LAST_SLOT_E1 7'h1f
`define LAST_SLOT_E1X2 7'h3f
`define LAST_SLOT_E1X4 7'h7f

`endif

// ---- inc/tdm_port_pkg.sv ----
package tdm_port_pkg;
  `include "tdm_port_map.svh"

  typedef enum logic [2:0] {
    MODE_T1 = `MODE_T1,
    MODE_E1 = `MODE_E1,
    MODE_E1X2 = `MODE_E1X2,
    MODE_E1X4 = `MODE_E1X4,
    MODE_NX64 = `MODE_NX64
  } port_mode_e;

  typedef logic [6:0] slot_t;
  typedef logic [2:0] bit_idx_t;
endpackage

// ---- rtl/tdm_port_config.sv ----
`timescale 1ns/1ns
`include "tdm_port_map.svh"
// What this block does
// - one framing word per port drives both transmit and receive logic
// - drive-one clear, group enabled: unmapped slots leave data floating
// - drive-one set, group enabled: unmapped slots drive logic one
// - bit 8 picks receive clock edge sampling out-of-frame, 1 rising
// - bit 7 picks receive clock edge sampling frame sync, 1 rising
// - bit 6 picks receive clock edge sampling serial data, 1 rising
// - bit 5 picks transmit clock edge sampling frame sync, 1 rising
// - bit 4 picks transmit clock edge launching data, 1 rising
// - mode 0 is T1 framing with 24 slots per frame
// - mode 1 is E1 framing with 32 slots per frame
// - mode 2 is double E1 framing with 64 slots per frame
// - mode 3 is quad E1 framing with 128 slots per frame
// - mode 4 has no flywheel and no alignment change detection
// - mode 4 resets the slot counter on every frame sync
// - transmitter disabled keeps transmit data floating regardless of setup
module tdm_port_config
  import tdm_port_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [31:0] rdata,
  input wire logic tx_line_clock,
  input wire logic tx_frame_sync_in,
  output logic tx_serial_data_out,
  output logic tx_serial_data_oe,
  input wire logic rx_line_clock,
  input wire logic rx_serial_data_in,
  input wire logic rx_frame_sync_in,
  input wire logic rx_out_of_frame_in
);

  // last slot index of a frame; nx64 and reserved codes run the full range
  function automatic slot_t last_slot(input logic [2:0] mode);
    case (mode)
      `MODE_T1: last_slot = `LAST_SLOT_T1;
      `MODE_E1: last_slot = `LAST_SLOT_E1;
      `MODE_E1X2: last_slot = `LAST_SLOT_E1X2;
      default: last_slot = `LAST_SLOT_E1X4;
    endcase
  endfunction

  // ---------------- core domain: registers ----------------
  logic [31:0] serial_port_framing_config;
  logic [31:0] ctrl;
  logic [127:0] tx_map;
  logic frame_alignment_change_detect_sticky;
  logic [7:0] rx_byte_core;
  logic oof_s1, oof_s2;
  logic frame_alignment_change_detect_t1, frame_alignment_change_detect_t2, frame_alignment_change_detect_t3;
  logic byte_t1, byte_t2, byte_t3;
  logic rx_byte_toggle;
  logic frame_alignment_change_detect_toggle;
  logic rx_oof_q;
  logic [7:0] rx_byte_hold;
  logic frame_alignment_change_detect_event;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      serial_port_framing_config <= `CFG_RESET;
    end else if (wr_strobe && addr == `OFS_CONFIG) begin
      serial_port_framing_config <= wdata & `CFG_WRITE_MASK;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ctrl <= `CTRL_RESET;
    end else if (wr_strobe && addr == `OFS_CTRL) begin
      ctrl <= wdata & `CTRL_WRITE_MASK;
    end
  end

  genvar gm;
  generate
    for (gm = 0; gm < 4; gm++) begin : g_map
      always_ff @(posedge core_clk) begin
        if (!resetn) begin
          tx_map[gm*32 +: 32] <= `MAP_RESET;
        end else if (wr_strobe && addr == `OFS_MAP0 + 8'(gm * 4)) begin
          tx_map[gm*32 +: 32] <= wdata;
        end
      end
    end
  endgenerate

  // crossings from the receive side: level, event toggle, word toggle
  always_ff @(posedge core_clk) begin
    oof_s1 <= rx_oof_q;
    oof_s2 <= oof_s1;
    frame_alignment_change_detect_t1 <= frame_alignment_change_detect_toggle;
    frame_alignment_change_detect_t2 <= frame_alignment_change_detect_t1;
    frame_alignment_change_detect_t3 <= frame_alignment_change_detect_t2;
    byte_t1 <= rx_byte_toggle;
    byte_t2 <= byte_t1;
    byte_t3 <= byte_t2;
  end

  assign frame_alignment_change_detect_event = frame_alignment_change_detect_t2 ^ frame_alignment_change_detect_t3;

  // sticky, write one to clear; a new event wins over the clear
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      frame_alignment_change_detect_sticky <= 1'b0;
    end else if (frame_alignment_change_detect_event) begin
      frame_alignment_change_detect_sticky <= 1'b1;
    end else if (wr_strobe && addr == `OFS_STATUS && wdata[`STAT_FRAME_ALIGNMENT_CHANGE_DETECT]) begin
      frame_alignment_change_detect_sticky <= 1'b0;
    end
  end

  // hold register is stable for a whole frame around each toggle
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rx_byte_core <= 8'h00;
    end else if (byte_t2 ^ byte_t3) begin
      rx_byte_core <= rx_byte_hold;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rdata <= 32'h0000_0000;
    end else if (rd_strobe) begin
      case (addr)
        `OFS_CONFIG: rdata <= serial_port_framing_config;
        `OFS_CTRL: rdata <= ctrl;
        `OFS_STATUS: rdata <= {16'h0000, rx_byte_core, 6'h00,
                               frame_alignment_change_detect_sticky, oof_s2};
        `OFS_MAP0: rdata <= tx_map[31:0];
        `OFS_MAP1: rdata <= tx_map[63:32];
        `OFS_MAP2: rdata <= tx_map[95:64];
        `OFS_MAP3: rdata <= tx_map[127:96];
        default: rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  // ---------------- transmit line domain ----------------
  logic tx_rst_s1, tx_rst_n;
  logic [9:0] tx_cfg_s1, tx_cfg;
  logic [8:0] tx_ctl_s1, tx_ctl;
  logic [127:0] tx_map_s1, tx_map_q;
  logic tx_sync_neg, tx_sync_q, tx_sync_prev, tx_start;
  bit_idx_t tx_bit;
  slot_t tx_slot;
  logic tx_val_p, tx_oe_p, tx_val_n, tx_oe_n;
  logic tx_en, tx_mapped, tx_launch_rise, tx_nx64;

  always_ff @(posedge tx_line_clock) begin
    tx_rst_s1 <= resetn;
    tx_rst_n <= tx_rst_s1;
    tx_cfg_s1 <= serial_port_framing_config[9:0];
    tx_cfg <= tx_cfg_s1;
    tx_ctl_s1 <= {ctrl[`CTRL_FILL_MSB:`CTRL_FILL_LSB], ctrl[`CTRL_TX_ENABLE]};
    tx_ctl <= tx_ctl_s1;
    tx_map_s1 <= tx_map;
    tx_map_q <= tx_map_s1;
  end

  assign tx_en = tx_ctl[0];
  assign tx_mapped = tx_map_q[tx_slot];
  assign tx_launch_rise = tx_cfg[`CFG_TX_LAUNCH_EDGE];
  assign tx_nx64 = tx_cfg[`CFG_MODE_MSB:`CFG_MODE_LSB] == `MODE_NX64;
  assign tx_start = tx_sync_q && !tx_sync_prev;

  always_ff @(negedge tx_line_clock) begin
    tx_sync_neg <= tx_frame_sync_in;
  end

  always_ff @(posedge tx_line_clock) begin
    if (!tx_rst_n) begin
      tx_sync_q <= 1'b0;
      tx_sync_prev <= 1'b0;
    end else begin
      tx_sync_q <= tx_cfg[`CFG_TX_SYNC_EDGE] ? tx_frame_sync_in
                                             : tx_sync_neg;
      tx_sync_prev <= tx_sync_q;
    end
  end

  always_ff @(posedge tx_line_clock) begin
    if (!tx_rst_n) begin
      tx_bit <= 3'h0;
      tx_slot <= 7'h00;
    end else if (tx_start) begin
      tx_bit <= 3'h0;
      tx_slot <= 7'h00;
    end else begin
      tx_bit <= tx_bit + 3'h1;
      if (tx_bit == 3'h7) begin
        if (tx_nx64) begin
          tx_slot <= (tx_slot == 7'h7f) ? tx_slot : tx_slot + 7'h01;
        end else if (tx_slot == last_slot(tx_cfg[2:0])) begin
          tx_slot <= 7'h00;
        end else begin
          tx_slot <= tx_slot + 7'h01;
        end
      end
    end
  end

  always_ff @(posedge tx_line_clock) begin
    if (!tx_rst_n) begin
      tx_val_p <= 1'b1;
      tx_oe_p <= 1'b0;
    end else begin
      tx_val_p <= (tx_en && tx_mapped) ? tx_ctl[1 + tx_bit] : 1'b1;
      tx_oe_p <= tx_en && (tx_mapped || tx_cfg[`CFG_DRIVE_ONE]);
    end
  end

  always_ff @(negedge tx_line_clock) begin
    tx_val_n <= tx_val_p;
    tx_oe_n <= tx_oe_p && tx_rst_n;
  end

  // both candidates are flops; the edge bit only steers which one drives
  assign tx_serial_data_out = tx_launch_rise ? tx_val_p : tx_val_n;
  assign tx_serial_data_oe = tx_launch_rise ? tx_oe_p : tx_oe_n;

  // ---------------- receive line domain ----------------
  logic rx_rst_s1, rx_rst_n;
  logic [9:0] rx_cfg_s1, rx_cfg;
  logic [2:0] rx_pin, rx_neg, rx_smp, rx_edge;
  logic rx_sync_prev, rx_start, rx_nx64, rx_running, rx_frame_alignment_change_detect;
  bit_idx_t rx_bit;
  slot_t rx_slot;
  logic [7:0] rx_shift;

  always_ff @(posedge rx_line_clock) begin
    rx_rst_s1 <= resetn;
    rx_rst_n <= rx_rst_s1;
    rx_cfg_s1 <= serial_port_framing_config[9:0];
    rx_cfg <= rx_cfg_s1;
  end

  assign rx_pin = {rx_out_of_frame_in, rx_frame_sync_in, rx_serial_data_in};
  assign rx_edge = {rx_cfg[`CFG_OOF_EDGE], rx_cfg[`CFG_SYNC_EDGE],
                    rx_cfg[`CFG_DATA_EDGE]};
  assign rx_nx64 = rx_cfg[`CFG_MODE_MSB:`CFG_MODE_LSB] == `MODE_NX64;

  genvar gr;
  generate
    for (gr = 0; gr < 3; gr++) begin : g_rx_edge
      always_ff @(negedge rx_line_clock) begin
        rx_neg[gr] <= rx_pin[gr];
      end
      always_ff @(posedge rx_line_clock) begin
        if (!rx_rst_n) begin
          rx_smp[gr] <= 1'b0;
        end else begin
          rx_smp[gr] <= rx_edge[gr] ? rx_pin[gr] : rx_neg[gr];
        end
      end
    end
  endgenerate

  assign rx_start = rx_smp[1] && !rx_sync_prev;
  // outside nx64, a sync after the first, anywhere but the expected frame boundary, is an alignment change
  assign rx_frame_alignment_change_detect = rx_start && rx_running && !rx_nx64 &&
                   !(rx_bit == 3'h7 && rx_slot == last_slot(rx_cfg[2:0]));

  always_ff @(posedge rx_line_clock) begin
    if (!rx_rst_n) begin
      rx_sync_prev <= 1'b0;
      rx_running <= 1'b0;
      rx_oof_q <= 1'b0;
      frame_alignment_change_detect_toggle <= 1'b0;
    end else begin
      rx_sync_prev <= rx_smp[1];
      rx_running <= rx_running || rx_start;
      rx_oof_q <= rx_smp[2];
      frame_alignment_change_detect_toggle <= frame_alignment_change_detect_toggle ^ rx_frame_alignment_change_detect;
    end
  end

  always_ff @(posedge rx_line_clock) begin
    if (!rx_rst_n) begin
      rx_bit <= 3'h0;
      rx_slot <= 7'h00;
    end else if (rx_start) begin
      rx_bit <= 3'h0;
      rx_slot <= 7'h00;
    end else begin
      rx_bit <= rx_bit + 3'h1;
      if (rx_bit == 3'h7) begin
        if (rx_nx64) begin
          rx_slot <= (rx_slot == 7'h7f) ? rx_slot : rx_slot + 7'h01;
        end else if (rx_slot == last_slot(rx_cfg[2:0])) begin
          rx_slot <= 7'h00;
        end else begin
          rx_slot <= rx_slot + 7'h01;
        end
      end
    end
  end

  always_ff @(posedge rx_line_clock) begin
    if (!rx_rst_n) begin
      rx_shift <= 8'h00;
      rx_byte_hold <= 8'h00;
      rx_byte_toggle <= 1'b0;
    end else begin
      rx_shift <= {rx_smp[0], rx_shift[7:1]};
      if (rx_bit == 3'h0 && rx_slot == 7'h01) begin
        rx_byte_hold <= rx_shift;
        rx_byte_toggle <= !rx_byte_toggle;
      end
    end
  end

  // ---------------- assertions ----------------
  a_cfg_write_mask: assert property (@(posedge core_clk) disable iff (!resetn)
    wr_strobe && addr == `OFS_CONFIG |=>
    serial_port_framing_config == ($past(wdata) & `CFG_WRITE_MASK))
    else $error("config word not stored masked");

  a_tx_disabled_float: assert property (@(posedge tx_line_clock)
    disable iff (!tx_rst_n) !tx_en |=> !tx_oe_p)
    else $error("transmit driven while disabled");

  a_unmapped_float: assert property (@(posedge tx_line_clock)
    disable iff (!tx_rst_n)
    tx_en && !tx_mapped && !tx_cfg[`CFG_DRIVE_ONE] |=> !tx_oe_p)
    else $error("unmapped slot not floating");

  a_unmapped_one: assert property (@(posedge tx_line_clock)
    disable iff (!tx_rst_n)
    tx_en && !tx_mapped && tx_cfg[`CFG_DRIVE_ONE] |=> tx_oe_p && tx_val_p)
    else $error("unmapped slot not driving one");

  a_launch_fall: assert property (@(posedge tx_line_clock)
    disable iff (!tx_rst_n)
    !tx_launch_rise && $stable(tx_launch_rise) |->
    tx_serial_data_out == tx_val_p)
    else $error("data not launched on falling edge");

  a_tx_sync_fall: assert property (@(posedge tx_line_clock)
    disable iff (!tx_rst_n)
    !tx_cfg[`CFG_TX_SYNC_EDGE] |=> tx_sync_q == $past(tx_sync_neg))
    else $error("transmit sync edge wrong");

  a_oof_fall: assert property (@(posedge rx_line_clock) disable iff (!rx_rst_n)
    !rx_cfg[`CFG_OOF_EDGE] |=> rx_smp[2] == $past(rx_neg[2]))
    else $error("out-of-frame edge wrong");

  a_sync_rise: assert property (@(posedge rx_line_clock) disable iff (!rx_rst_n)
    rx_cfg[`CFG_SYNC_EDGE] |=> rx_smp[1] == $past(rx_frame_sync_in))
    else $error("receive sync edge wrong");

  a_data_rise: assert property (@(posedge rx_line_clock) disable iff (!rx_rst_n)
    rx_cfg[`CFG_DATA_EDGE] |=> rx_smp[0] == $past(rx_serial_data_in))
    else $error("receive data edge wrong");

  a_t1_wrap: assert property (@(posedge rx_line_clock) disable iff (!rx_rst_n)
    rx_cfg[2:0] == `MODE_T1 && rx_bit == 3'h7 && rx_slot == 7'h17 &&
    !rx_start |=> rx_slot == 7'h00)
    else $error("T1 frame not 24 slots");

  a_e1_wrap: assert property (@(posedge rx_line_clock) disable iff (!rx_rst_n)
    rx_cfg[2:0] == `MODE_E1 && rx_bit == 3'h7 && rx_slot == 7'h1f &&
    !rx_start |=> rx_slot == 7'h00)
    else $error("E1 frame not 32 slots");

  a_e1x2_wrap: assert property (@(posedge rx_line_clock) disable iff (!rx_rst_n)
    rx_cfg[2:0] == `MODE_E1X2 && rx_bit == 3'h7 && rx_slot == 7'h3f &&
    !rx_start |=> rx_slot == 7'h00)
    else $error("double E1 frame not 64 slots");

  a_e1x4_wrap: assert property (@(posedge tx_line_clock) disable iff (!tx_rst_n)
    tx_cfg[2:0] == `MODE_E1X4 && tx_bit == 3'h7 && tx_slot == 7'h7f &&
    !tx_start |=> tx_slot == 7'h00)
    else $error("quad E1 frame not 128 slots");

  a_nx64_no_frame_alignment_change_detect: assert property (@(posedge rx_line_clock)
    disable iff (!rx_rst_n) rx_nx64 |-> !rx_frame_alignment_change_detect)
    else $error("alignment change flagged in nx64");

  a_nx64_sync_reset: assert property (@(posedge rx_line_clock)
    disable iff (!rx_rst_n)
    rx_nx64 && rx_start |=> rx_slot == 7'h00 && rx_bit == 3'h0)
    else $error("nx64 sync did not reset slot counter");

  c_frame_alignment_change_detect_seen: cover property (@(posedge core_clk) disable iff (!resetn)
    frame_alignment_change_detect_event ##[1:4] rd_strobe && addr == `OFS_STATUS);
  c_nx64_sync: cover property (@(posedge rx_line_clock) disable iff (!rx_rst_n)
    rx_nx64 && rx_start && rx_slot != 7'h00);
  c_drive_one: cover property (@(posedge tx_line_clock) disable iff (!tx_rst_n)
    tx_en && !tx_mapped && tx_cfg[`CFG_DRIVE_ONE]);
  c_mapped_data: cover property (@(posedge tx_line_clock)
    disable iff (!tx_rst_n) tx_en && tx_mapped ##1 !tx_val_p);

endmodule // tdm_port_config

// ---- verif/tdm_framer_model.sv ----
`timescale 1ns/1ns
// line side framer: free running line clocks, sync and receive patterns
module tdm_framer_model (
  input wire logic clr,
  input wire logic sync_on,
  input wire logic sync_at_rise,
  input wire logic launch_rise,
  input wire logic tx_serial_data_out,
  input wire logic tx_serial_data_oe,
  output logic tx_line_clock,
  output logic rx_line_clock,
  output logic tx_frame_sync_in,
  output logic rx_frame_sync_in,
  output logic rx_serial_data_in,
  output logic rx_out_of_frame_in,
  output int nbit,
  output int oe_cnt,
  output int one_cnt,
  output int rises,
  output int period,
  output logic launch_hi
);
  int bcnt = 0;
  int since = 0;
  logic prev_oe = 1'b0;
  logic near_rise;

  // sample transmit pins on the edge opposite the launch edge
  task automatic sample();
    nbit++;
    since++;
    if (tx_serial_data_oe === 1'b1) begin
      oe_cnt++;
      if (tx_serial_data_out === 1'b1) one_cnt++;
    end
    if (tx_serial_data_oe === 1'b1 && prev_oe !== 1'b1) begin
      rises++;
      period = since;
      since = 0;
    end
    prev_oe = tx_serial_data_oe;
  endtask

  // clock rises at step 1, falls at step 4; each step is 5 ns
  // sync, data and out-of-frame are true only near one edge
  always begin
    for (int s = 0; s < 6; s++) begin
      if (s == 0 && clr) begin
        nbit = 0;
        oe_cnt = 0;
        one_cnt = 0;
        rises = 0;
      end
      if ((s == 1 && !launch_rise) || (s == 4 && launch_rise)) sample();
      near_rise = s < 3;
      tx_line_clock = s >= 1 && s < 4;
      rx_line_clock = tx_line_clock;
      tx_frame_sync_in = sync_on && bcnt == 0 && near_rise == sync_at_rise;
      rx_frame_sync_in = tx_frame_sync_in;
      rx_serial_data_in = near_rise;
      rx_out_of_frame_in = near_rise;
      #5;
    end
    bcnt = bcnt == 99 ? 0 : bcnt + 1;
  end

  always @(posedge tx_serial_data_oe) launch_hi = tx_line_clock;
endmodule // tdm_framer_model

// ---- verif/tb_tdm_port_config.sv ----
`timescale 1ns/1ns
`include "tdm_port_map.svh"
module tb_tdm_port_config;
  import tdm_port_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_strobe = 1'b0;
  logic rd_strobe = 1'b0;
  logic [31:0] rdata;
  logic tx_line_clock, rx_line_clock, tx_frame_sync_in, rx_frame_sync_in;
  logic rx_serial_data_in, rx_out_of_frame_in;
  logic tx_serial_data_out, tx_serial_data_oe, launch_hi;
  logic clr = 1'b1;
  logic sync_on = 1'b0;
  logic sync_at_rise = 1'b0;
  logic launch_rise = 1'b1;
  int nbit, oe_cnt, one_cnt, rises, period;
  int fails = 0;
  int checks_done = 0;
  logic [31:0] rv;
  int slots [4] = '{24, 32, 64, 128};

  always #5 core_clk = ~core_clk;

  tdm_port_config dut (.core_clk(core_clk), .resetn(resetn), .addr(addr),
    .wdata(wdata), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
    .rdata(rdata), .tx_line_clock(tx_line_clock),
    .tx_frame_sync_in(tx_frame_sync_in),
    .tx_serial_data_out(tx_serial_data_out),
    .tx_serial_data_oe(tx_serial_data_oe), .rx_line_clock(rx_line_clock),
    .rx_serial_data_in(rx_serial_data_in),
    .rx_frame_sync_in(rx_frame_sync_in),
    .rx_out_of_frame_in(rx_out_of_frame_in));

  tdm_framer_model framer (.clr(clr), .sync_on(sync_on),
    .sync_at_rise(sync_at_rise), .launch_rise(launch_rise),
    .tx_serial_data_out(tx_serial_data_out),
    .tx_serial_data_oe(tx_serial_data_oe), .tx_line_clock(tx_line_clock),
    .rx_line_clock(rx_line_clock), .tx_frame_sync_in(tx_frame_sync_in),
    .rx_frame_sync_in(rx_frame_sync_in),
    .rx_serial_data_in(rx_serial_data_in),
    .rx_out_of_frame_in(rx_out_of_frame_in), .nbit(nbit), .oe_cnt(oe_cnt),
    .one_cnt(one_cnt), .rises(rises), .period(period),
    .launch_hi(launch_hi));

  task automatic end_sim();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr_strobe <= 1'b1;
    @(posedge core_clk);
    wr_strobe <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge core_clk);
    rd_strobe <= 1'b0;
    #1;
    d = rdata;
  endtask

  // restart the framer counters, then wait for line bits or oe rises
  task automatic restart();
    clr <= 1'b1;
    repeat (4) @(posedge core_clk);
    clr <= 1'b0;
  endtask

  task automatic wait_bits(input int n);
    restart();
    for (int i = 0; i < 4 * n + 100 && nbit < n; i++) @(posedge core_clk);
    chk(32'(nbit >= n), 32'h1, "bit wait ran out");
  endtask

  task automatic wait_rises(input int k);
    restart();
    for (int i = 0; i < 15000 && rises < k; i++) @(posedge core_clk);
    chk(32'(rises >= k), 32'h1, "frame wait ran out");
  endtask

  task automatic drive_case(input logic [31:0] cfg, input logic [31:0] ctl,
                            input logic all);
    wr(`OFS_CONFIG, cfg);
    wr(`OFS_CTRL, ctl);
    wait_bits(40);
    wait_bits(300);
    chk(32'(oe_cnt), all ? 32'(nbit) : 32'h0, "oe bit count");
    chk(32'(one_cnt), all ? 32'(nbit) : 32'h0, "ones bit count");
  endtask

  task automatic rx_case(input logic [31:0] cfg, input logic [31:0] exp);
    wr(`OFS_CONFIG, cfg);
    wait_bits(300);
    wr(`OFS_STATUS, 32'h0000_0002);
    wait_bits(300);
    rd(`OFS_STATUS, rv);
    chk(rv & 32'h0000_ff03, exp, "receive status");
  endtask

  initial begin
    #1_000_000;
    fails++;
    $display("ERROR %0t: watchdog expired", $time);
    end_sim();
  end

  initial begin
    // line domains need three line clock edges inside reset
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    rd(`OFS_CONFIG, rv);
    chk(rv, `CFG_RESET, "config reset");
    rd(`OFS_CTRL, rv);
    chk(rv, `CTRL_RESET, "ctrl reset");
    rd(`OFS_MAP3, rv);
    chk(rv, `MAP_RESET, "map reset");
    wr(`OFS_CONFIG, 32'hffff_ffff);
    rd(`OFS_CONFIG, rv);
    chk(rv, `CFG_WRITE_MASK, "config mask");
    wr(`OFS_CTRL, 32'hffff_ffff);
    rd(`OFS_CTRL, rv);
    chk(rv, `CTRL_WRITE_MASK, "ctrl mask");
    wr(`OFS_MAP1, 32'hffff_ffff);
    rd(`OFS_MAP1, rv);
    chk(rv, 32'hffff_ffff, "map write");
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40, rv);
    chk(rv, 32'h0, "unmapped read");
    wr(`OFS_MAP1, 32'h0);
    $display("test registers done");
    wr(`OFS_CTRL, 32'h0000_a501);
    wr(`OFS_MAP0, 32'h0000_0001);
    for (int m = 0; m < 4; m++) begin
      wr(`OFS_CONFIG, 32'h0000_0010 | m);
      wait_rises(3);
      chk(32'(period), 32'(slots[m] * 8), "frame length");
    end
    chk({31'h0, launch_hi}, 32'h1, "rising launch");
    launch_rise <= 1'b0;
    wr(`OFS_CONFIG, 32'h0000_0001);
    wait_rises(3);
    chk(32'(period), 32'd256, "frame length falling");
    chk({31'h0, launch_hi}, 32'h0, "falling launch");
    launch_rise <= 1'b1;
    $display("test framing done");
    wr(`OFS_MAP0, 32'h0);
    drive_case(32'h0000_0211, 32'h0000_0001, 1'b1);
    drive_case(32'h0000_0011, 32'h0000_0001, 1'b0);
    drive_case(32'h0000_0211, 32'h0000_0000, 1'b0);
    $display("test unmapped drive done");
    wr(`OFS_CTRL, 32'h0000_a501);
    wr(`OFS_MAP0, 32'h0000_0001);
    sync_on <= 1'b1;
    wr(`OFS_CONFIG, 32'h0000_0014);
    wait_rises(3);
    chk(32'(period), 32'd100, "sync restart");
    sync_at_rise <= 1'b1;
    wait_bits(200);
    wait_bits(300);
    chk(32'(rises), 32'h0, "no flywheel");
    wr(`OFS_CONFIG, 32'h0000_0034);
    wait_rises(3);
    chk(32'(period), 32'd100, "sync rising");
    $display("test nx64 done");
    rx_case(32'h0000_01c1, 32'h0000_ff03);
    rx_case(32'h0000_0001, 32'h0000_0000);
    rx_case(32'h0000_01c4, 32'h0000_ff01);
    $display("test receive done");
    end_sim();
  end
endmodule // tb_tdm_port_config
